// ### ccpu_capture_compare_unit.sv
// Module: four-channel capture/compare unit with AXI4-Lite registers
// Function
// - Timer pick bit selects timer one or three
// - Each channel runs on its own mode and timer pick, sharing timers
// - Open-drain bits 6:3 switch output drivers
// - Capture copies selected 16-bit timer value
// - Capture on fall, rise, 4th, 16th edge
// - Capture sets sticky flag until software clears
// - New capture overwrites held value
// - Prescaler cleared when off, in compare codes, on capture, reset
// - Prescaler switch keeps count, may flag
// - Channel zero may capture on CAN receive
// - CAN capture codes use same prescaling
// - Compare match acts on pin in codes 0010/1000/1001, sets flag
// - Writing zero control clears compare latch
// - Code 1010 only flags, pin untouched
// - Codes 1000/1001 initialise then force on match
// - Code 0010 toggles pin on match
// - Code 0000 disables and resets channel
// - Code 1011 resets assigned timer on match
`timescale 1ns/1ps
module ccpu_capture_compare_unit #(
  parameter int NUM_CHANNELS = 4
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output      logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output      logic        s_axi_wready,
  output      logic [1:0]  s_axi_bresp,
  output      logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output      logic        s_axi_arready,
  output      logic [31:0] s_axi_rdata,
  output      logic [1:0]  s_axi_rresp,
  output      logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [15:0] timebase_one,
  input  wire logic [15:0] timebase_three,
  input  wire logic [3:0]  pin_in,
  input  wire logic        can_rx_event,
  output      logic [3:0]  pin_out,
  output      logic [3:0]  pin_oe,
  output      logic        timebase_one_reset,
  output      logic        timebase_three_reset
);
  import ccpu_pkg::*;

  // ****************************************
  // Elaboration check
  // ****************************************
  if (NUM_CHANNELS != NUM_MOD) begin : gen_bad_count
    $error("NUM_CHANNELS must equal 4");
  end

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0]  module_control_reg [NUM_MOD];
  logic [15:0] value_reg [NUM_MOD];
  logic [4:0]  timer_assign_reg;
  logic [7:0]  open_drain_control;
  logic [3:0]  event_flag_reg;
  logic [7:0]  can_io_control;
  logic [3:0]  port_latch_reg;

  ccpu_chan_cfg_t  cfg  [NUM_MOD];
  ccpu_chan_stat_t stat [NUM_MOD];

  // ****************************************
  // AXI4-Lite handshake state
  // ****************************************
  logic        aw_held_reg;
  logic [7:0]  aw_addr_reg;
  logic        w_held_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;
  logic        awready_reg;
  logic        wready_reg;
  logic        arready_reg;
  logic [31:0] rd_mux;

  wire aw_take = s_axi_awvalid && awready_reg;
  wire w_take  = s_axi_wvalid && wready_reg;
  wire do_wr   = aw_held_reg && w_held_reg && !bvalid_reg;
  wire ar_take = s_axi_arvalid && arready_reg;

  function automatic logic [4:0] decode(input logic [7:0] a);
    // Bit 4: valid, bits 3:0: register number
    if (a[1:0] != 2'b00) begin
      decode = 5'h00;
    end else if (a < 8'h10) begin
      decode = {1'b1, 2'b00, a[3:2]};
    end else if (a < 8'h20) begin
      decode = {1'b1, 2'b01, a[3:2]};
    end else if (a <= PORT_LATCH_ADDR) begin
      decode = {1'b1, 4'h8 + {2'b00, a[3:2]} + ((a >= 8'h30) ? 4'h4 : 4'h0)};
    end else begin
      decode = 5'h00;
    end
  endfunction

  // ****************************************
  // Address decode
  // ****************************************
  wire [4:0] wr_dec = decode(aw_addr_reg);
  wire [4:0] rd_dec = decode(s_axi_araddr);
  wire       wr_ok  = wr_dec[4];
  wire       wr_en  = do_wr && wr_ok;  // Unmapped writes change nothing
  wire [3:0] wr_sel = wr_dec[3:0];
  wire [3:0] rd_sel = rd_dec[3:0];

  // Write data merged with byte strobes, only low 16 bits matter
  wire [15:0] wmask = {{8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= CCPU_RESP_OKAY;
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= CCPU_RESP_OKAY;
    end else begin
      awready_reg <= !aw_held_reg && !aw_take && !bvalid_reg;
      wready_reg  <= !w_held_reg && !w_take && !bvalid_reg;
      if (aw_take) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (w_take) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= wr_ok ? CCPU_RESP_OKAY : CCPU_RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
      arready_reg <= !rvalid_reg && !ar_take;
      if (ar_take) begin
        rvalid_reg <= 1'b1;
        rresp_reg  <= rd_dec[4] ? CCPU_RESP_OKAY : CCPU_RESP_SLVERR;
        rdata_reg  <= rd_dec[4] ? rd_mux : 32'h0000_0000;
      end else if (rvalid_reg && s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // ****************************************
  // Read multiplexer
  // ****************************************
  always_comb begin
    case (rd_sel)
      4'h0, 4'h1, 4'h2, 4'h3: rd_mux = {24'h00_0000, module_control_reg[rd_sel[1:0]]};
      4'h4, 4'h5, 4'h6, 4'h7: rd_mux = {16'h0000, value_reg[rd_sel[1:0]]};
      4'h8:    rd_mux = {27'h000_0000, timer_assign_reg};
      4'h9:    rd_mux = {24'h00_0000, open_drain_control};
      4'hA:    rd_mux = {28'h000_0000, event_flag_reg};
      4'hB:    rd_mux = {24'h00_0000, can_io_control};
      4'hC:    rd_mux = {28'h000_0000, port_latch_reg};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_assign_reg   <= 5'h00;
      open_drain_control <= 8'h00;
      can_io_control     <= 8'h00;
      port_latch_reg     <= 4'h0;
    end else if (wr_en && w_strb_reg[0]) begin
      if (wr_sel == 4'h8) timer_assign_reg <= w_data_reg[4:0];
      if (wr_sel == 4'h9) open_drain_control <= w_data_reg[7:0] & 8'h7C;
      if (wr_sel == 4'hB) can_io_control <= w_data_reg[7:0];
      if (wr_sel == 4'hC) port_latch_reg <= w_data_reg[3:0];
    end
  end

  // ****************************************
  // Channels
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < NUM_MOD; g++) begin : gen_chan
      wire wr_ctrl  = wr_en && w_strb_reg[0] && (wr_sel == 4'(g));
      wire wr_value = wr_en && (wr_sel == 4'(4 + g));
      wire flag_clr = wr_en && w_strb_reg[0] && (wr_sel == 4'hA) && w_data_reg[g];

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          module_control_reg[g] <= CTRL_RST;
          value_reg[g]          <= VALUE_RST;
          event_flag_reg[g]     <= 1'b0;
        end else begin
          if (wr_ctrl) module_control_reg[g] <= w_data_reg[7:0] & 8'h3F;
          if (stat[g].capture_strobe) begin
            value_reg[g] <= stat[g].captured;
          end else if (wr_value) begin
            value_reg[g] <= (w_data_reg[15:0] & wmask) | (value_reg[g] & ~wmask);
          end
          // Hardware set wins over software clear
          if (stat[g].event_pulse) event_flag_reg[g] <= 1'b1;
          else if (flag_clr) event_flag_reg[g] <= 1'b0;
        end
      end

      assign cfg[g].mode              = module_control_reg[g][3:0];
      assign cfg[g].timer_pick        = timer_assign_reg[g + 1];
      assign cfg[g].open_drain_select = open_drain_control[g + OD_LSB + 1];
      assign cfg[g].can_source        = (g == 0) ? can_io_control[CAN_TIMESTAMP_SELECT_BIT] : 1'b0;
      assign cfg[g].port_latch        = port_latch_reg[g];
      assign cfg[g].compare_value     = value_reg[g];
      assign cfg[g].value_write       = wr_value;

      ccpu_channel u_chan (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .cfg           (cfg[g]),
        .timebase_one  (timebase_one),
        .timebase_three(timebase_three),
        .pin_in        (pin_in[g]),
        .can_rx_event  (can_rx_event),
        .stat          (stat[g])
      );
    end
  endgenerate

  // ****************************************
  // Timer reset routing
  // ****************************************
  logic [3:0] rst_one;
  logic [3:0] rst_three;
  always_comb begin
    for (int i = 0; i < NUM_MOD; i++) begin
      rst_one[i]   = stat[i].timer_reset && !cfg[i].timer_pick;
      rst_three[i] = stat[i].timer_reset && cfg[i].timer_pick;
    end
  end

  // ****************************************
  // Output registers
  // ****************************************
  logic [3:0] pin_out_reg;
  logic [3:0] pin_oe_reg;
  logic       t1_rst_reg;
  logic       t3_rst_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_out_reg <= 4'h0;
      pin_oe_reg  <= 4'h0;
      t1_rst_reg  <= 1'b0;
      t3_rst_reg  <= 1'b0;
    end else begin
      for (int i = 0; i < NUM_MOD; i++) begin
        pin_out_reg[i] <= stat[i].pin_out;
        pin_oe_reg[i]  <= stat[i].pin_oe;
      end
      t1_rst_reg <= |rst_one;
      t3_rst_reg <= |rst_three;
    end
  end

  // ****************************************
  // Output ports
  // ****************************************
  assign s_axi_awready        = awready_reg;
  assign s_axi_wready         = wready_reg;
  assign s_axi_bvalid         = bvalid_reg;
  assign s_axi_bresp          = bresp_reg;
  assign s_axi_arready        = arready_reg;
  assign s_axi_rvalid         = rvalid_reg;
  assign s_axi_rdata          = rdata_reg;
  assign s_axi_rresp          = rresp_reg;
  assign pin_out              = pin_out_reg;
  assign pin_oe               = pin_oe_reg;
  assign timebase_one_reset   = t1_rst_reg;
  assign timebase_three_reset = t3_rst_reg;
endmodule

// ### ccpu_pkg.sv
// Package: register map, mode codes and shared types of the capture/compare unit
package ccpu_pkg;

  localparam int NUM_MOD     = 4;
  localparam int TIMER_W     = 16;

  // Register byte addresses
  localparam logic [7:0] CTRL_BASE_ADDR  = 8'h00;
  localparam logic [7:0] VALUE_BASE_ADDR = 8'h10;
  localparam logic [7:0] TIMER_ASSIGN_ADDR = 8'h20;
  localparam logic [7:0] OPEN_DRAIN_ADDR   = 8'h24;
  localparam logic [7:0] FLAG_ADDR         = 8'h28;
  localparam logic [7:0] CAN_IO_ADDR       = 8'h2C;
  localparam logic [7:0] PORT_LATCH_ADDR   = 8'h30;

  // Field positions
  localparam int OD_LSB      = 2;
  localparam int CAN_TIMESTAMP_SELECT_BIT  = 4;
  localparam int PRESC_MAX   = 15;

  // Reset values
  localparam logic [7:0]  CTRL_RST  = 8'h00;
  localparam logic [15:0] VALUE_RST = 16'h0000;

  // Mode codes
  localparam logic [3:0] MODE_OFF      = 4'h0;
  localparam logic [3:0] MODE_TOGGLE   = 4'h2;
  localparam logic [3:0] MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE = 4'h5;
  localparam logic [3:0] MODE_CAP_4    = 4'h6;
  localparam logic [3:0] MODE_CAP_16   = 4'h7;
  localparam logic [3:0] MODE_SET_HI   = 4'h8;
  localparam logic [3:0] MODE_SET_LO   = 4'h9;
  localparam logic [3:0] MODE_SWINT    = 4'hA;
  localparam logic [3:0] MODE_SPECIAL  = 4'hB;

  typedef enum logic [1:0] {CCPU_RESP_OKAY = 2'b00, CCPU_RESP_SLVERR = 2'b10} ccpu_resp_t;

  // One channel's view of the world
  typedef struct packed {
    logic [3:0]  mode;
    logic        timer_pick;
    logic        open_drain_select;
    logic        can_source;
    logic        port_latch;
    logic [15:0] compare_value;
    logic        value_write;
  } ccpu_chan_cfg_t;

  typedef struct packed {
    logic [15:0] captured;
    logic        capture_strobe;
    logic        event_pulse;
    logic        timer_reset;
    logic        pin_out;
    logic        pin_oe;
  } ccpu_chan_stat_t;

endpackage

// ### ccpu_channel.sv
// Module: one capture/compare channel
`timescale 1ns/1ps
module ccpu_channel (
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  input  wire ccpu_pkg::ccpu_chan_cfg_t cfg,
  input  wire logic [15:0]              timebase_one,
  input  wire logic [15:0]              timebase_three,
  input  wire logic                     pin_in,
  input  wire logic                     can_rx_event,
  output      ccpu_pkg::ccpu_chan_stat_t stat
);
  import ccpu_pkg::*;

  logic [1:0]  sync_reg;
  logic        last_reg;
  logic [3:0]  presc_reg;
  logic [3:0]  presc_next;
  logic [3:0]  prev_mode_reg;
  logic        out_reg;
  logic        match_reg;
  logic [15:0] captured_reg;
  logic        capture_reg;
  logic        event_reg;
  logic        treset_reg;

  wire [15:0] timer_sel   = cfg.timer_pick ? timebase_three : timebase_one;
  wire        is_capture  = (cfg.mode[3:2] == 2'b01);
  wire        is_compare  = (cfg.mode == MODE_TOGGLE) || (cfg.mode[3:2] == 2'b10);
  wire        rise        = sync_reg[1] & ~last_reg;
  wire        fall        = ~sync_reg[1] & last_reg;
  wire        src_event   = cfg.can_source ? can_rx_event : ((cfg.mode == MODE_CAP_FALL) ? fall : rise);
  wire [3:0]  presc_top   = (cfg.mode == MODE_CAP_16) ? 4'(PRESC_MAX) : ((cfg.mode == MODE_CAP_4) ? 4'h3 : 4'h0);
  wire        presc_hit   = src_event && (presc_reg >= presc_top);
  wire        cap_fire    = is_capture && presc_hit;
  wire        match       = is_compare && (timer_sel == cfg.compare_value);
  wire        match_rise  = match && !match_reg;
  wire        entry       = cfg.mode != prev_mode_reg;

  assign presc_next = (!is_capture) ? 4'h0 : (presc_hit ? 4'h0 : (src_event ? presc_reg + 4'h1 : presc_reg));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_reg      <= 2'b00;
      last_reg      <= 1'b0;
      presc_reg     <= 4'h0;
      prev_mode_reg <= MODE_OFF;
      out_reg       <= 1'b0;
      match_reg     <= 1'b0;
      captured_reg  <= VALUE_RST;
      capture_reg   <= 1'b0;
      event_reg     <= 1'b0;
      treset_reg    <= 1'b0;
    end else begin
      sync_reg      <= {sync_reg[0], pin_in};
      last_reg      <= sync_reg[1];
      presc_reg     <= presc_next;
      prev_mode_reg <= cfg.mode;
      match_reg     <= match;
      capture_reg   <= cap_fire;
      event_reg     <= cap_fire || match_rise;
      treset_reg    <= match_rise && (cfg.mode == MODE_SPECIAL);
      if (cap_fire) begin
        captured_reg <= timer_sel;
      end
      if (cfg.mode == MODE_OFF) begin
        out_reg <= 1'b0;
      end else if (entry && cfg.mode == MODE_SET_HI) begin
        out_reg <= 1'b0;
      end else if (entry && cfg.mode == MODE_SET_LO) begin
        out_reg <= 1'b1;
      end else if (match_rise) begin
        case (cfg.mode)
          MODE_SET_HI: out_reg <= 1'b1;
          MODE_SET_LO: out_reg <= 1'b0;
          MODE_TOGGLE: out_reg <= ~out_reg;
          default:     out_reg <= out_reg;
        endcase
      end
    end
  end

  // Pin drive: compare latch only in drive modes, else the port latch
  wire drive_mode = is_compare && (cfg.mode != MODE_SWINT) && (cfg.mode != MODE_SPECIAL);
  wire level      = drive_mode ? out_reg : cfg.port_latch;

  assign stat.captured       = captured_reg;
  assign stat.capture_strobe = capture_reg;
  assign stat.event_pulse    = event_reg;
  assign stat.timer_reset    = treset_reg;
  assign stat.pin_out        = cfg.open_drain_select ? 1'b0 : level;
  assign stat.pin_oe         = cfg.open_drain_select ? ~level : 1'b1;
endmodule

// ### ccpu_capture_compare_unit_props.sv
// Checker: bus handshake, timer reset and pin drive relations of the unit
`timescale 1ns/1ps
module ccpu_unit_props #(
  parameter int NUM_CHANNELS = 4
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [3:0]  pin_out,
  input wire logic [3:0]  pin_oe,
  input wire logic        timebase_one_reset,
  input wire logic        timebase_three_reset
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read response changed early");
  write_refused_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  read_refused_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while response pending");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
  one_reset_pulse_a: assert property (timebase_one_reset |=> !timebase_one_reset)
    else $error("timer one reset longer than one cycle");
  three_reset_pulse_a: assert property (timebase_three_reset |=> !timebase_three_reset)
    else $error("timer three reset longer than one cycle");
  drive_level_a: assert property ((pin_out & ~pin_oe) == 4'h0)
    else $error("pin high without drive enable");
endmodule

// ### ccpu_timer_model.sv
// Partner model: two shared timers and the CAN receive event source
`timescale 1ns/1ps
module ccpu_timer_model (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        hold,
  input  wire logic        load,
  input  wire logic [15:0] preset,
  input  wire logic        t1_rst,
  input  wire logic        t3_rst,
  input  wire logic        can_fire,
  output      logic [15:0] timebase_one,
  output      logic [15:0] timebase_three,
  output      logic        can_rx_event
);
  logic half_reg;
  // Timers count on aclk only; timer three at half rate
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timebase_one <= 16'h0000;
      timebase_three <= 16'h0000;
      half_reg <= 1'b0;
      can_rx_event <= 1'b0;
    end else begin
      half_reg <= ~half_reg;
      can_rx_event <= can_fire;
      if (load) begin
        timebase_one <= preset;
        timebase_three <= ~preset;
      end else if (!hold) begin
        timebase_one <= t1_rst ? 16'h0000 : timebase_one + 16'h0001;
        timebase_three <= t3_rst ? 16'h0000 : timebase_three + {15'h0000, half_reg};
      end
    end
  end
endmodule

// ### ccpu_capture_compare_unit_test.sv
// Testbench: self-checking run of the capture/compare unit
`timescale 1ns/1ps
module ccpu_capture_compare_unit_test;
  import ccpu_pkg::*;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, hold, load, can_fire;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata;
  logic [3:0]  pin_in;
  logic [15:0] preset, base, cv;
  wire  logic  awready, wready, bvalid, arready, rvalid, t1_rst, t3_rst, can_rx;
  wire  logic [1:0]  bresp, rresp;
  wire  logic [31:0] rdata;
  wire  logic [15:0] t1, t3;
  wire  logic [3:0]  pin_out, pin_oe;
  logic [33:0] exp_q[$];
  logic [3:0]  cmp_mode[4] = '{MODE_SET_HI, MODE_SET_LO, MODE_TOGGLE, MODE_SWINT};
  int          err_total = 0;
  int          checked = 0;

  ccpu_capture_compare_unit #(.NUM_CHANNELS(4)) dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .timebase_one(t1), .timebase_three(t3), .pin_in(pin_in),
    .can_rx_event(can_rx), .pin_out(pin_out), .pin_oe(pin_oe), .timebase_one_reset(t1_rst),
    .timebase_three_reset(t3_rst));
  ccpu_timer_model partner (.aclk(aclk), .aresetn(aresetn), .hold(hold), .load(load), .preset(preset),
    .t1_rst(t1_rst), .t3_rst(t3_rst), .can_fire(can_fire), .timebase_one(t1), .timebase_three(t3),
    .can_rx_event(can_rx));

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  // ****************
  // Shared tasks
  // ****************
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("errors=%0d checks=%0d", err_total, checked);
    if (err_total == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'b00);
    int n;
    n = 0;
    exp_q.push_back({r, 32'h0000_0000});
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 50);
    if (!bvalid) err_total++;
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'b00);
    int n;
    n = 0;
    exp_q.push_back({r, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 50);
    if (!rvalid) err_total++;
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic tload(input logic [15:0] v);
    preset <= v;
    load <= 1'b1;
    cyc(1);
    load <= 1'b0;
    cyc(1);
  endtask
  task automatic pulse(input int k);
    tload(base + 16'(k));
    pin_in <= 4'hF;
    cyc(8);
    pin_in <= 4'h0;
    cyc(8);
  endtask
  task automatic canev(input int k);
    tload(base + 16'(k));
    can_fire <= 1'b1;
    cyc(1);
    can_fire <= 1'b0;
    cyc(8);
  endtask
  function automatic logic [31:0] cap(input int g, input int k);
    logic [15:0] v;
    v = base + 16'(k);
    if (k == 0) return 32'h0000_0000;
    return {16'h0000, g[0] ? ~v : v};
  endfunction
  function automatic logic [7:0] ofs(input int g);
    return 8'(g * 4);
  endfunction

  // Oldest expectation meets each bus answer
  always @(posedge aclk) begin
    if (rvalid && rready) chk({rresp, rdata}, exp_q.pop_front());
    if (bvalid && bready) chk({bresp, 32'h0000_0000}, exp_q.pop_front());
  end

  initial begin
    cyc(60000);
    err_total++;
    complete_run();
  end

  // ****************
  // Main sequence
  // ****************
  initial begin
    int n;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, load, can_fire} = 7'h00;
    {awaddr, araddr, wdata, pin_in, preset} = '0;
    hold = 1'b1;
    void'($urandom(28962));
    base = 16'($urandom);
    cv = 16'($urandom);
    cyc(4);
    aresetn <= 1'b1;
    rd(CTRL_BASE_ADDR, 32'h0000_0000);
    rd(VALUE_BASE_ADDR, 32'h0000_0000);
    rd(8'h34, 32'h0000_0000, CCPU_RESP_SLVERR);
    wr(8'h34, 32'h0000_0001, CCPU_RESP_SLVERR);
    rd(CTRL_BASE_ADDR, 32'h0000_0000);
    wr(TIMER_ASSIGN_ADDR, 32'h0000_0014);
    for (int g = 0; g < 4; g++) wr(CTRL_BASE_ADDR + ofs(g), 32'(MODE_CAP_FALL + g));
    wr(FLAG_ADDR, 32'h0000_000F);
    for (int k = 1; k < 16; k++) pulse(k);
    for (int g = 0; g < 4; g++) rd(VALUE_BASE_ADDR + ofs(g), cap(g, g == 2 ? 12 : g == 3 ? 0 : 15));
    rd(FLAG_ADDR, 32'h0000_0007);
    wr(FLAG_ADDR, 32'h0000_000F);
    rd(FLAG_ADDR, 32'h0000_0000);
    pulse(16);
    for (int g = 0; g < 4; g++) rd(VALUE_BASE_ADDR + ofs(g), cap(g, 16));
    rd(FLAG_ADDR, 32'h0000_000F);
    pulse(17);
    wr(CTRL_BASE_ADDR + ofs(2), 32'h0000_0000);
    wr(CTRL_BASE_ADDR + ofs(2), 32'(MODE_CAP_4));
    pulse(18);
    pulse(19);
    wr(CTRL_BASE_ADDR + ofs(2), 32'(MODE_CAP_16));
    for (int k = 20; k < 33; k++) pulse(k);
    rd(VALUE_BASE_ADDR + ofs(2), cap(2, 16));
    pulse(33);
    rd(VALUE_BASE_ADDR + ofs(2), cap(2, 33));
    wr(CAN_IO_ADDR, 32'h0000_0010);
    wr(CTRL_BASE_ADDR, 32'h0000_0000);
    wr(CTRL_BASE_ADDR, 32'(MODE_CAP_FALL));
    canev(40);
    pulse(41);
    rd(VALUE_BASE_ADDR, cap(0, 40));
    wr(CTRL_BASE_ADDR, 32'h0000_0000);
    wr(CTRL_BASE_ADDR, 32'(MODE_CAP_4));
    for (int k = 42; k < 45; k++) canev(k);
    rd(VALUE_BASE_ADDR, cap(0, 40));
    canev(45);
    rd(VALUE_BASE_ADDR, cap(0, 45));
    for (int g = 0; g < 4; g++) wr(CTRL_BASE_ADDR + ofs(g), 32'h0000_0000);
    wr(TIMER_ASSIGN_ADDR, 32'h0000_0000);
    wr(OPEN_DRAIN_ADDR, 32'h0000_0010);
    wr(PORT_LATCH_ADDR, 32'h0000_0008);
    tload(cv - 16'h0014);
    for (int g = 0; g < 4; g++) wr(VALUE_BASE_ADDR + ofs(g), {16'h0000, cv});
    for (int g = 0; g < 4; g++) wr(CTRL_BASE_ADDR + ofs(g), 32'(cmp_mode[g]));
    wr(FLAG_ADDR, 32'h0000_000F);
    chk(pin_out, 4'b1000);
    chk(pin_oe, 4'b1101);
    hold <= 1'b0;
    cyc(40);
    hold <= 1'b1;
    chk(pin_out, 4'b1101);
    chk(pin_oe, 4'b1111);
    rd(FLAG_ADDR, 32'h0000_000F);
    wr(CTRL_BASE_ADDR, 32'h0000_0000);
    cyc(3);
    chk(pin_out, 4'b1100);
    wr(TIMER_ASSIGN_ADDR, 32'h0000_0010);
    tload(~(cv - 16'h000A));
    wr(CTRL_BASE_ADDR + ofs(3), 32'(MODE_SPECIAL));
    hold <= 1'b0;
    n = 0;
    while (!t3_rst && n < 60) begin
      cyc(1);
      n++;
    end
    chk(t3_rst, 1'b1);
    chk(t1_rst, 1'b0);
    complete_run();
  end
endmodule

bind ccpu_capture_compare_unit ccpu_unit_props #(.NUM_CHANNELS(NUM_CHANNELS)) u_props (.aclk(aclk),
  .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .pin_out(pin_out), .pin_oe(pin_oe), .timebase_one_reset(timebase_one_reset),
  .timebase_three_reset(timebase_three_reset));
